// ---- verification/pcs_decoder_model.sv ----
// Purpose: instruction decoder stand-in that feeds the fetch unit
// Assumes: tasks are called just after a rising clock edge
// Notes: idle operand lines show inverted data so a stale value never looks valid
`include "pcs_regs.svh"

module pcs_decoder_model (
	// clock
	input wire logic i_sys_clk,
	// operation and high latch write
	output pcs_pkg::pcs_op_e o_op,
	output logic [`PCS_TGT_W-1:0] o_target,
	output logic [`PCS_BYTE_W-1:0] o_low_data,
	output logic o_latch_we,
	output logic [`PCS_BYTE_W-1:0] o_latch_data
);
	timeunit 1ns;
	timeprecision 100ps;

	// quiet decoder at time zero
	initial begin
		o_op = pcs_pkg::PCS_OP_NONE;
		o_target = '0;
		o_low_data = '0;
		o_latch_we = 1'b0;
		o_latch_data = '0;
	end

	// one finished instruction per call; the low byte sum never carries up
	task automatic issue(input pcs_pkg::pcs_op_e op, input logic [`PCS_TGT_W-1:0] tgt,
		input logic [`PCS_BYTE_W-1:0] dat);
		o_op = op;
		o_target = tgt;
		o_low_data = dat;
		@(posedge i_sys_clk);
		#1;
	endtask

	// no instruction ends this cycle
	task automatic idle;
		o_op = pcs_pkg::PCS_OP_NONE;
		o_target = ~o_target;
		o_low_data = ~o_low_data;
		@(posedge i_sys_clk);
		#1;
	endtask

	// page bits are written before a jump needs them
	task automatic set_latch(input logic [`PCS_BYTE_W-1:0] v);
		o_op = pcs_pkg::PCS_OP_NONE;
		o_target = ~o_target;
		o_low_data = ~o_low_data;
		o_latch_we = 1'b1;
		o_latch_data = v;
		@(posedge i_sys_clk);
		#1;
		o_latch_we = 1'b0;
		o_latch_data = ~v;
	endtask
endmodule

// ---- verification/pcs_fetch_unit_tb.sv ----
// Purpose: self-checking bench for the program counter and return stack
// Assumes: every input changes 1 ns after a rising edge
// Notes: table rows run as one sequence, so each row starts where the last ended
`include "pcs_regs.svh"

module pcs_fetch_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [7:0] latch;
		pcs_pkg::pcs_op_e op;
		logic [10:0] tgt;
		logic [7:0] dat;
		logic [12:0] pc;
	} pcs_row_s;

	logic i_sys_clk;
	logic i_rst_b;
	pcs_pkg::pcs_op_e i_op;
	logic [`PCS_TGT_W-1:0] i_target;
	logic [`PCS_BYTE_W-1:0] i_low_data;
	logic i_latch_we;
	logic [`PCS_BYTE_W-1:0] i_latch_data;
	logic i_wake_wdt;
	logic i_wake_irq;
	logic i_global_irq_enable;
	pcs_pkg::pcs_addr_t o_pc;
	logic [`PCS_BYTE_W-1:0] o_counter_low_byte_reg;
	logic [`PCS_BYTE_W-1:0] o_counter_high_latch;
	logic o_asleep;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;

	// latch, operation, operands and the address that must follow
	pcs_row_s rows [12] = '{
		'{8'h1B, pcs_pkg::PCS_OP_GOTO, 11'h5A5, 8'h00, 13'h1DA5},
		'{8'hE9, pcs_pkg::PCS_OP_WRITE_LOW, 11'h000, 8'h3C, 13'h093C},
		'{8'hE9, pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00, 13'h093D},
		'{8'h10, pcs_pkg::PCS_OP_CALL, 11'h7FF, 8'h00, 13'h17FF},
		'{8'h08, pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00, 13'h093E},
		'{8'h00, pcs_pkg::PCS_OP_CALL, 11'h123, 8'h00, 13'h0123},
		'{8'h18, pcs_pkg::PCS_OP_RET_LIT, 11'h000, 8'h00, 13'h093F},
		'{8'h08, pcs_pkg::PCS_OP_IRQ_VECTOR, 11'h000, 8'h00, 13'h0004},
		'{8'h1F, pcs_pkg::PCS_OP_RET_IRQ, 11'h000, 8'h00, 13'h0940},
		'{8'h1F, pcs_pkg::pcs_op_e'(4'hC), 11'h000, 8'h00, 13'h0940},
		'{8'h02, pcs_pkg::PCS_OP_WRITE_LOW, 11'h000, 8'hFF, 13'h02FF},
		'{8'h02, pcs_pkg::PCS_OP_NONE, 11'h000, 8'h00, 13'h02FF}
	};

	pcs_decoder_model i_dec (
		.i_sys_clk(i_sys_clk),
		.o_op(i_op),
		.o_target(i_target),
		.o_low_data(i_low_data),
		.o_latch_we(i_latch_we),
		.o_latch_data(i_latch_data)
	);

	pcs_fetch_unit i_dut (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_op(i_op),
		.i_target(i_target),
		.i_low_data(i_low_data),
		.i_latch_we(i_latch_we),
		.i_latch_data(i_latch_data),
		.i_wake_wdt(i_wake_wdt),
		.i_wake_irq(i_wake_irq),
		.i_global_irq_enable(i_global_irq_enable),
		.o_pc(o_pc),
		.o_counter_low_byte_reg(o_counter_low_byte_reg),
		.o_counter_high_latch(o_counter_high_latch),
		.o_asleep(o_asleep)
	);

	// 200 MHz clock
	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	// hang guard; the whole run needs about 65 cycles
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 1000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one wake pulse; irq selects the source
	task automatic wake(input logic irq, input logic global_irq_enable);
		i_global_irq_enable = global_irq_enable;
		i_wake_irq = irq;
		i_wake_wdt = ~irq;
		@(posedge i_sys_clk);
		#1;
		i_wake_irq = 1'b0;
		i_wake_wdt = 1'b0;
	endtask

	task automatic report_and_stop;
		$display("checked %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		i_rst_b = 1'b0;
		i_wake_wdt = 1'b0;
		i_wake_irq = 1'b0;
		i_global_irq_enable = 1'b0;
		repeat (5) @(posedge i_sys_clk);
		#1;
		i_rst_b = 1'b1;
		check(o_pc, 13'h0000);
		check({5'h00, o_counter_high_latch}, 13'h0000);
		check({12'h000, o_asleep}, 13'h0000);
		$display("test reset done");
		foreach (rows[i]) begin
			i_dec.set_latch(rows[i].latch);
			i_dec.issue(rows[i].op, rows[i].tgt, rows[i].dat);
			check(o_pc, rows[i].pc);
			check({5'h00, o_counter_low_byte_reg}, {5'h00, rows[i].pc[7:0]});
			check({5'h00, o_counter_high_latch}, {5'h00, rows[i].latch});
		end
		$display("test table done");
		// ten calls into an eight-deep stack, then nine returns
		for (int k = 1; k <= 10; k++) begin
			i_dec.issue(pcs_pkg::PCS_OP_CALL, 11'(16 * k), 8'h00);
		end
		for (int k = 10; k >= 2; k--) begin
			i_dec.issue(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
			check(o_pc, 13'(k == 2 ? 145 : 16 * k - 15));
		end
		$display("test stack wrap done");
		// operations are ignored while asleep; watchdog wake resumes one further
		i_dec.issue(pcs_pkg::PCS_OP_SLEEP, 11'h000, 8'h00);
		check({12'h000, o_asleep}, 13'h0001);
		i_dec.issue(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
		check(o_pc, 13'h0091);
		i_dec.idle();
		wake(1'b0, 1'b0);
		check(o_pc, 13'h0092);
		check({12'h000, o_asleep}, 13'h0000);
		// interrupt wake with enable vectors after one instruction
		i_dec.issue(pcs_pkg::PCS_OP_SLEEP, 11'h000, 8'h00);
		i_dec.idle();
		wake(1'b1, 1'b1);
		check(o_pc, 13'h0093);
		i_dec.issue(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
		check(o_pc, 13'h0004);
		i_dec.issue(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
		check(o_pc, 13'h0094);
		// interrupt wake without enable runs on normally
		i_dec.issue(pcs_pkg::PCS_OP_SLEEP, 11'h000, 8'h00);
		i_dec.idle();
		wake(1'b1, 1'b0);
		i_dec.issue(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
		check(o_pc, 13'h0096);
		$display("test sleep and wake done");
		// reset in mid-run clears the counter at once
		i_rst_b = 1'b0;
		#1;
		check(o_pc, 13'h0000);
		check({5'h00, o_counter_high_latch}, 13'h0000);
		@(posedge i_sys_clk);
		#1;
		i_rst_b = 1'b1;
		// first edge after release keeps the cleared values
		i_dec.idle();
		check(o_pc, 13'h0000);
		check({12'h000, o_asleep}, 13'h0000);
		// running restarts from address zero
		i_dec.issue(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
		check(o_pc, 13'h0001);
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule

// ---- verilog/pcs_fetch_unit.sv ----
// Purpose: program counter, high latch and return stack of the 8-bit core
// Assumes: decoder gives one operation per cycle; wake pulses only while asleep
// Notes: one clock; every reset source is merged onto i_rst_b beforehand
`include "pcs_regs.svh"

module pcs_fetch_unit (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// decoder operation
	input wire pcs_pkg::pcs_op_e i_op,
	input wire logic [`PCS_TGT_W-1:0] i_target,
	input wire logic [`PCS_BYTE_W-1:0] i_low_data,
	// high latch write from the register file
	input wire logic i_latch_we,
	input wire logic [`PCS_BYTE_W-1:0] i_latch_data,
	// sleep and wake-up
	input wire logic i_wake_wdt,
	input wire logic i_wake_irq,
	input wire logic i_global_irq_enable,
	// fetch address and readable state
	output pcs_pkg::pcs_addr_t o_pc,
	output logic [`PCS_BYTE_W-1:0] o_counter_low_byte_reg,
	output logic [`PCS_BYTE_W-1:0] o_counter_high_latch,
	output logic o_asleep
);

	pcs_pkg::pcs_addr_t pc;
	pcs_pkg::pcs_addr_t next_pc;
	pcs_pkg::pcs_state_e state;
	pcs_pkg::pcs_state_e next_state;
	logic [`PCS_BYTE_W-1:0] counter_high_latch;
	logic asleep;
	logic next_asleep;

	// stack and address helpers
	pcs_pkg::pcs_addr_t stack_top;
	pcs_pkg::pcs_addr_t mux_next_pc;
	pcs_pkg::pcs_addr_t mux_return_addr;
	pcs_pkg::pcs_addr_t push_data;
	logic mux_push;
	logic mux_pop;
	logic push;
	logic pop;
	logic wake;
	logic op_done;

	assign wake = i_wake_wdt | i_wake_irq;
	assign op_done = (i_op != pcs_pkg::PCS_OP_NONE);

	// next address for a running core
	pcs_next_addr u_next_addr (
		.i_op(i_op),
		.i_pc(pc),
		.i_high_latch(counter_high_latch),
		.i_stack_top(stack_top),
		.i_target(i_target),
		.i_low_data(i_low_data),
		.o_next_pc(mux_next_pc),
		.o_push(mux_push),
		.o_pop(mux_pop),
		.o_return_addr(mux_return_addr)
	);

	// eight deep circular return stack
	pcs_return_stack #(
		.DEPTH(`PCS_STACK_DEPTH)
	) u_stack (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_push(push),
		.i_pop(pop),
		.i_push_data(push_data),
		.o_top(stack_top)
	);

	// sequencing across run, sleep and the deferred interrupt vector
	always_comb begin
		next_state = state;
		next_pc = pc;
		push = 1'b0;
		pop = 1'b0;
		push_data = mux_return_addr;
		unique case (state)
			pcs_pkg::PCS_RUN: begin
				next_pc = mux_next_pc;
				push = mux_push;
				pop = mux_pop;
				if (i_op == pcs_pkg::PCS_OP_SLEEP) begin
					next_state = pcs_pkg::PCS_SLEEP;
				end
			end
			pcs_pkg::PCS_SLEEP: begin
				// decoder operations are ignored while asleep
				if (wake) begin
					next_pc = pc + `PCS_PC_INC;
					if (i_wake_irq && i_global_irq_enable) begin
						next_state = pcs_pkg::PCS_WAKE_VEC;
					end else begin
						next_state = pcs_pkg::PCS_RUN;
					end
				end
			end
			pcs_pkg::PCS_WAKE_VEC: begin
				// first instruction after wake runs, then the vector wins;
				// its own stack action is dropped so only one push happens
				if (op_done) begin
					next_pc = `PCS_IRQ_VECTOR;
					push = 1'b1;
					push_data = mux_next_pc;
					next_state = pcs_pkg::PCS_RUN;
				end
			end
			default: begin
				next_state = pcs_pkg::PCS_RUN;
			end
		endcase
	end

	assign next_asleep = (next_state == pcs_pkg::PCS_SLEEP);

	// program counter; any reset starts at address zero
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pc <= `PCS_RESET_PC;
		end else begin
			pc <= next_pc;
		end
	end

	// sequencing state
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= pcs_pkg::PCS_RUN;
			asleep <= 1'b0;
		end else begin
			state <= next_state;
			asleep <= next_asleep;
		end
	end

	// high latch changes only on its own write, never on stack traffic
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			counter_high_latch <= `PCS_LATCH_RESET;
		end else if (i_latch_we) begin
			counter_high_latch <= i_latch_data;
		end
	end

	// outputs straight from the flops; upper counter bits leave only through o_pc
	assign o_pc = pc;
	assign o_counter_low_byte_reg = pc[`PCS_BYTE_W-1:0];
	assign o_counter_high_latch = counter_high_latch;
	assign o_asleep = asleep;

	// a write to the low byte takes the upper bits from the latch
	a_low_write_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state == pcs_pkg::PCS_RUN) && (i_op == pcs_pkg::PCS_OP_WRITE_LOW)
		|=> o_pc == {$past(counter_high_latch[`PCS_UPPER_MSB:0]), $past(i_low_data)})
		else $error("low byte write did not load latch bits into counter");

	// goto stays within the page chosen by the latch
	a_goto_page_select: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state == pcs_pkg::PCS_RUN) && (i_op == pcs_pkg::PCS_OP_GOTO)
		|=> o_pc == {$past(counter_high_latch[`PCS_PAGE_MSB:`PCS_PAGE_LSB]), $past(i_target)})
		else $error("goto target page is wrong");

	// call followed at once by return resumes after the call
	a_call_return_pair: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state == pcs_pkg::PCS_RUN) && (i_op == pcs_pkg::PCS_OP_CALL)
		##1 (state == pcs_pkg::PCS_RUN) && (i_op == pcs_pkg::PCS_OP_RETURN)
		|=> o_pc == pcs_pkg::pcs_addr_t'($past(o_pc, 2) + `PCS_PC_INC))
		else $error("return did not resume after the call");

	// every return flavour restores the whole counter from the stack
	a_return_restore: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state == pcs_pkg::PCS_RUN) && ((i_op == pcs_pkg::PCS_OP_RETURN)
		|| (i_op == pcs_pkg::PCS_OP_RET_LIT) || (i_op == pcs_pkg::PCS_OP_RET_IRQ))
		|=> o_pc == $past(stack_top))
		else $error("return did not restore the popped address");

	// stack traffic leaves the latch alone
	a_latch_kept_stack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(push || pop) && !i_latch_we |=> $stable(o_counter_high_latch))
		else $error("high latch changed on a push or pop");

	// asleep with no wake on two cycles running: counter holds on the next one
	a_sleep_hold_pc: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state == pcs_pkg::PCS_SLEEP) && !wake ##1 (state == pcs_pkg::PCS_SLEEP) && !wake
		|=> $stable(o_pc) && o_asleep)
		else $error("counter moved while asleep");

	// wake-up continues at counter plus one, never at zero
	a_wake_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state == pcs_pkg::PCS_SLEEP) && wake
		|=> o_pc == pcs_pkg::pcs_addr_t'($past(o_pc) + `PCS_PC_INC) && !o_asleep)
		else $error("wake-up did not resume at counter plus one");

	// interrupt wake with enable: one instruction, then the vector
	a_wake_vector: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state == pcs_pkg::PCS_SLEEP) && i_wake_irq && i_global_irq_enable
		##1 (i_op == pcs_pkg::PCS_OP_STEP)
		|=> o_pc == `PCS_IRQ_VECTOR ##1 o_pc == `PCS_IRQ_VECTOR || $changed(o_pc))
		else $error("interrupt wake-up did not vector after one instruction");

	// interrupt vectoring jumps to the vector and pushes
	a_irq_vector_push: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(state == pcs_pkg::PCS_RUN) && (i_op == pcs_pkg::PCS_OP_IRQ_VECTOR)
		|-> push && (push_data == pcs_pkg::pcs_addr_t'(o_pc + `PCS_PC_INC))
		##1 o_pc == `PCS_IRQ_VECTOR)
		else $error("interrupt vectoring did not push and branch");

endmodule

// ---- verilog/pcs_next_addr.sv ----
// Purpose: next program address and stack request for one finished instruction
// Assumes: latch value is the registered one, writes to it land a cycle later
// Notes: purely combinational
`include "pcs_regs.svh"

module pcs_next_addr (
	// current state
	input wire pcs_pkg::pcs_op_e i_op,
	input wire pcs_pkg::pcs_addr_t i_pc,
	input wire logic [`PCS_BYTE_W-1:0] i_high_latch,
	input wire pcs_pkg::pcs_addr_t i_stack_top,
	// operands from the decoder
	input wire logic [`PCS_TGT_W-1:0] i_target,
	input wire logic [`PCS_BYTE_W-1:0] i_low_data,
	// results
	output pcs_pkg::pcs_addr_t o_next_pc,
	output logic o_push,
	output logic o_pop,
	output pcs_pkg::pcs_addr_t o_return_addr
);

	// return address is always the following instruction
	assign o_return_addr = i_pc + `PCS_PC_INC;

	// choose next address by how the instruction ends
	always_comb begin
		o_next_pc = i_pc;
		o_push = 1'b0;
		o_pop = 1'b0;
		unique case (i_op)
			pcs_pkg::PCS_OP_NONE,
			pcs_pkg::PCS_OP_SLEEP: begin
				o_next_pc = i_pc;
			end
			pcs_pkg::PCS_OP_STEP: begin
				o_next_pc = o_return_addr;
			end
			pcs_pkg::PCS_OP_GOTO: begin
				// page bits trusted as software left them
				o_next_pc = {i_high_latch[`PCS_PAGE_MSB:`PCS_PAGE_LSB], i_target};
			end
			pcs_pkg::PCS_OP_CALL: begin
				o_next_pc = {i_high_latch[`PCS_PAGE_MSB:`PCS_PAGE_LSB], i_target};
				o_push = 1'b1;
			end
			pcs_pkg::PCS_OP_RETURN,
			pcs_pkg::PCS_OP_RET_LIT,
			pcs_pkg::PCS_OP_RET_IRQ: begin
				o_next_pc = i_stack_top;
				o_pop = 1'b1;
			end
			pcs_pkg::PCS_OP_WRITE_LOW: begin
				// byte arrives already summed; no carry reaches upper bits
				o_next_pc = {i_high_latch[`PCS_UPPER_MSB:0], i_low_data};
			end
			pcs_pkg::PCS_OP_IRQ_VECTOR: begin
				o_next_pc = `PCS_IRQ_VECTOR;
				o_push = 1'b1;
			end
			default: begin
				o_next_pc = i_pc; // unused codes hold the counter
			end
		endcase
	end

endmodule

// ---- verilog/pcs_pkg.sv ----
// Purpose: shared types for the program counter and return stack unit
// Assumes: pcs_regs.svh holds every figure
// Notes: operation codes come from the instruction decoder
`include "pcs_regs.svh"

package pcs_pkg;

	// full program address
	typedef logic [`PCS_PC_W-1:0] pcs_addr_t;

	// how the current instruction ends, as told by the decoder
	typedef enum logic [3:0] {
		PCS_OP_NONE = 4'h0,
		PCS_OP_STEP = 4'h1,
		PCS_OP_GOTO = 4'h2,
		PCS_OP_CALL = 4'h3,
		PCS_OP_RETURN = 4'h4,
		PCS_OP_RET_LIT = 4'h5,
		PCS_OP_RET_IRQ = 4'h6,
		PCS_OP_WRITE_LOW = 4'h7,
		PCS_OP_IRQ_VECTOR = 4'h8,
		PCS_OP_SLEEP = 4'h9
	} pcs_op_e;

	// run, sleep, and the one-instruction wait before an interrupt vector
	typedef enum logic [1:0] {
		PCS_RUN = 2'h0,
		PCS_SLEEP = 2'h1,
		PCS_WAKE_VEC = 2'h2
	} pcs_state_e;

endpackage

// ---- verilog/pcs_regs.svh ----
// Purpose: constants for the program counter and return stack unit
// Assumes: included by bare name wherever a figure is needed
// Notes: widths, reset values and address figures live only here
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// widths
`define PCS_PC_W 13
`define PCS_BYTE_W 8
`define PCS_TGT_W 11
`define PCS_PAGE_MSB 4
`define PCS_PAGE_LSB 3
`define PCS_UPPER_MSB 4
`define PCS_STACK_DEPTH 8

// reset and fixed addresses
`define PCS_RESET_PC 13'h0000
`define PCS_IRQ_VECTOR 13'h0004
`define PCS_PC_INC 13'h0001
`define PCS_LATCH_RESET 8'h00

`endif

// ---- verilog/pcs_return_stack.sv ----
// Purpose: circular return address stack
// Assumes: push and pop are never asked together
// Notes: pointer wraps silently; nothing flags overflow or underflow
`include "pcs_regs.svh"

module pcs_return_stack #(
	parameter int DEPTH = `PCS_STACK_DEPTH,
	parameter int PTR_W = $clog2(DEPTH)
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// stack actions
	input wire logic i_push,
	input wire logic i_pop,
	input wire pcs_pkg::pcs_addr_t i_push_data,
	// newest entry
	output pcs_pkg::pcs_addr_t o_top
);

	pcs_pkg::pcs_addr_t mem [DEPTH];
	logic [PTR_W-1:0] ptr;

	// entries live outside program and data space
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= `PCS_RESET_PC;
			end
		end else if (i_push) begin
			mem[ptr] <= i_push_data;
		end
	end

	// hidden pointer; wraps so the ninth push lands on the first slot
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ptr <= '0;
		end else if (i_push) begin
			ptr <= ptr + PTR_W'(1);
		end else if (i_pop) begin
			ptr <= ptr - PTR_W'(1);
		end
	end

	assign o_top = mem[ptr - PTR_W'(1)];

	a_push_then_top: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_push |=> o_top == $past(i_push_data))
		else $error("pushed address is not on top of stack");

endmodule
